// ===== core/converter_io_pkg.sv
// Shared constants and types for the serial converter control block
// Summary of operation
// - Rising conversion-start strobe begins a conversion and puts the track/hold into hold.
// - Result word is 16 bits: two zeros, then the 14-bit result, MSB first.
// - Output bits change on receive-clock rise; receiver samples on fall while frame is low.
// - Frame strobe falls at conversion start; first zero valid at first falling clock edge.
// - Receive clock, frame strobe and data only pull low or release.
// - Receive clock comes from master clock; mode input selects gated or continuous.
// - Output side has input latch and converter latch; only the latter sets output.
// - Host presents 16 bits, each valid at a falling transmit-clock edge; device captures there.
// - Asserted frame sync marks the next 16 falling transmit-clock edges as word bits.
// - First two received bits are ignored; remaining 14, MSB first, form the code.
// - Normally the load strobe's falling edge copies input latch to converter latch.
// - Load strobe held low updates the converter latch on the sixteenth falling edge.
// - Load strobe falling mid-word does not update; staying low updates at sixteenth edge.
// - Load strobe falling then rising mid-word gives no converter-latch update.
// - Output code is two's complement: 1FFF max, 2000 min, 0000 zero volts.
// - Sampling code is two's complement: 1FFF max, 2000 min, 3FFF/0000 around zero.
// - Conversion lasts 19 or 20 master-clock rises; always 19 with gated internal clock.
package converter_io_pkg;

  localparam int unsigned CLK_FREQ_HZ       = 40_000_000;
  localparam int unsigned MCLK_FREQ_HZ      = 2_000_000;
  localparam int unsigned MCLK_HALF_CYCLES  = CLK_FREQ_HZ / (2 * MCLK_FREQ_HZ);

  localparam int unsigned CODE_BITS         = 14;
  localparam int unsigned WORD_BITS         = 16;
  localparam int unsigned LEAD_BITS         = WORD_BITS - CODE_BITS;
  localparam int unsigned CONV_RISE_EDGES   = 19;

  localparam logic [4:0]  DIV_LAST          = 5'(MCLK_HALF_CYCLES - 1);
  localparam logic [4:0]  CONV_LAST_EDGE    = 5'(CONV_RISE_EDGES - 1);
  localparam logic [4:0]  WORD_LAST_BIT     = 5'(WORD_BITS - 1);
  localparam logic [LEAD_BITS-1:0] LEAD_ZEROS = '0;

  typedef logic [CODE_BITS-1:0] code_t;
  typedef logic [WORD_BITS-1:0] word_t;

  // Open-drain pin: out is always low, oeN low pulls the wire low
  typedef struct packed {
    logic out;
    logic oeN;
  } odPin_t;

  localparam odPin_t PIN_RELEASED = '{out: 1'b0, oeN: 1'b1};
  localparam odPin_t PIN_LOW      = '{out: 1'b0, oeN: 1'b0};

endpackage

// ===== core/master_clock_divider.sv
// Divider that makes the converter master clock as level and edge enables
`timescale 1ns/1ps
`default_nettype none
module master_clock_divider
  import converter_io_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      level,
  output logic      riseEn,
  output logic      fallEn
);

  typedef struct packed {
    logic [4:0] count;
    logic       level;
    logic       rise;
    logic       fall;
  } divState_t;

  divState_t state_q;
  divState_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.rise = 1'b0;
    state_d.fall = 1'b0;
    if (restart) begin
      // Restart high so the first edge seen outside is a fall
      state_d.count = '0;
      state_d.level = 1'b1;
    end else if (state_q.count == DIV_LAST) begin
      state_d.count = '0;
      state_d.level = ~state_q.level;
      state_d.rise  = ~state_q.level;
      state_d.fall  = state_q.level;
    end else begin
      state_d.count = state_q.count + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{count: 5'h00, level: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign level  = state_q.level;
  assign riseEn = state_q.rise;
  assign fallEn = state_q.fall;

endmodule
`default_nettype wire

// ===== core/output_latch_pair.sv
// Input latch and converter latch of the output converter
`timescale 1ns/1ps
`default_nettype none
module output_latch_pair
  import converter_io_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  writeInput,
  input  wire code_t writeData,
  input  wire logic  transfer,
  output code_t      outputCode
);

  typedef struct packed {
    code_t inputLatch;
    code_t converterLatch;
  } latchState_t;

  latchState_t state_q;
  latchState_t state_d;

  always_comb begin
    state_d = state_q;
    if (writeInput) begin
      state_d.inputLatch = writeData;
    end
    // A transfer in the same cycle as a write takes the new word
    if (transfer) begin
      state_d.converterLatch = writeInput ? writeData : state_q.inputLatch;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Two's complement code drives the analog stage unchanged
  assign outputCode = state_q.converterLatch;

endmodule
`default_nettype wire

// ===== core/serial_adc_dac_interface.sv
// Conversion control, receive serialiser and transmit deserialiser of the converter pair
`timescale 1ns/1ps
`default_nettype none
module serial_adc_dac_interface
  import converter_io_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   conversionStartStrobeN,
  input  wire converter_io_pkg::code_t sampleCode,
  input  wire logic                   receiveClockContinuous,
  input  wire logic                   transmitSerialClock,
  input  wire logic                   transmitFrameSyncN,
  input  wire logic                   transmitDataIn,
  input  wire logic                   outputLatchLoadStrobeN,
  output converter_io_pkg::odPin_t    receiveClockPin,
  output converter_io_pkg::odPin_t    receiveFrameStrobe,
  output converter_io_pkg::odPin_t    receiveDataPin,
  output logic                        trackHoldHold,
  output logic                        converting,
  output converter_io_pkg::code_t     outputCode
);

  typedef struct packed {
    logic       startPrev;
    logic       converting;
    logic       hold;
    logic       skipRise;
    logic [4:0] riseCount;
    logic       framing;
    logic       fallSeen;
    logic [4:0] bitIdx;
    word_t      txShift;
    odPin_t     clkPin;
    odPin_t     framePin;
    odPin_t     dataPin;
    logic       tclkPrev;
    logic       loadPrev;
    logic       wordBusy;
    logic [4:0] wordCount;
    word_t      rxShift;
  } ifState_t;

  ifState_t state_q;
  ifState_t state_d;

  logic  mclkLevel;
  logic  mclkRise;
  logic  mclkFall;
  logic  startEdge;
  logic  divRestart;
  logic  tclkFall;
  logic  wordDone;
  logic  writeInput;
  logic  transfer;
  word_t wordIn;

  function automatic odPin_t driveLevel(input logic bitValue);
    driveLevel = bitValue ? PIN_RELEASED : PIN_LOW;
  endfunction

  // Starts during a conversion or frame are ignored
  assign startEdge  = ~state_q.startPrev & conversionStartStrobeN
                      & ~state_q.converting & ~state_q.framing;
  // Gated clock restarts in phase with the start, so timing is fixed
  assign divRestart = startEdge & ~receiveClockContinuous;

  master_clock_divider u_divider (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (divRestart),
    .level   (mclkLevel),
    .riseEn  (mclkRise),
    .fallEn  (mclkFall)
  );

  assign tclkFall = state_q.tclkPrev & ~transmitSerialClock;
  assign wordIn   = {state_q.rxShift[WORD_BITS-2:0], transmitDataIn};
  assign wordDone = tclkFall & state_q.wordBusy & (state_q.wordCount == WORD_LAST_BIT);

  always_comb begin
    state_d            = state_q;
    state_d.startPrev  = conversionStartStrobeN;
    state_d.tclkPrev   = transmitSerialClock;
    state_d.loadPrev   = outputLatchLoadStrobeN;
    writeInput         = 1'b0;
    transfer           = 1'b0;

    // Receive side: conversion and serial result
    if (startEdge) begin
      state_d.converting = 1'b1;
      state_d.hold       = 1'b1;
      state_d.riseCount  = '0;
      // A start landing on a clock rise misses that edge: one extra rise
      state_d.skipRise   = receiveClockContinuous & mclkRise;
      state_d.framing    = 1'b1;
      // A master fall in the start cycle reaches the pin with the frame, so it is the first fall
      state_d.fallSeen   = receiveClockContinuous & mclkFall;
      state_d.bitIdx     = '0;
      state_d.txShift    = {LEAD_ZEROS, sampleCode};
      state_d.framePin   = PIN_LOW;
      state_d.dataPin    = driveLevel(LEAD_ZEROS[LEAD_BITS-1]);
    end else begin
      if (state_q.converting && mclkRise) begin
        if (state_q.skipRise) begin
          state_d.skipRise = 1'b0;
        end else if (state_q.riseCount == CONV_LAST_EDGE) begin
          state_d.converting = 1'b0;
          state_d.hold       = 1'b0;
        end else begin
          state_d.riseCount = state_q.riseCount + 5'h01;
        end
      end
      if (state_q.framing && mclkFall) begin
        state_d.fallSeen = 1'b1;
      end
      // Next bit only after the current one was offered on a falling edge
      if (state_q.framing && mclkRise && state_q.fallSeen) begin
        state_d.fallSeen = 1'b0;
        if (state_q.bitIdx == WORD_LAST_BIT) begin
          state_d.framing  = 1'b0;
          state_d.framePin = PIN_RELEASED;
          state_d.dataPin  = PIN_RELEASED;
        end else begin
          state_d.bitIdx  = state_q.bitIdx + 5'h01;
          state_d.txShift = {state_q.txShift[WORD_BITS-2:0], 1'b0};
          state_d.dataPin = driveLevel(state_q.txShift[WORD_BITS-2]);
        end
      end
    end

    // Receive clock follows the master clock, gated unless continuous
    // A gated restart keeps the pin released, so no runt low pulse meets the new frame
    if (!divRestart && (receiveClockContinuous || state_d.converting || state_d.framing) && !mclkLevel) begin
      state_d.clkPin = PIN_LOW;
    end else begin
      state_d.clkPin = PIN_RELEASED;
    end

    // Transmit side: word capture on falling transmit-clock edges
    if (tclkFall) begin
      if (state_q.wordBusy) begin
        state_d.rxShift   = wordIn;
        state_d.wordCount = state_q.wordCount + 5'h01;
        if (wordDone) begin
          state_d.wordBusy = 1'b0;
          writeInput       = 1'b1;
          // Strobe low at the last bit commits the word at once
          transfer         = ~outputLatchLoadStrobeN;
        end
      end else if (!transmitFrameSyncN) begin
        state_d.wordBusy  = 1'b1;
        state_d.wordCount = 5'h01;
        state_d.rxShift   = wordIn;
      end
    end

    // Strobe edge outside a word copies the held word
    if (state_q.loadPrev && !outputLatchLoadStrobeN && !state_q.wordBusy) begin
      transfer = 1'b1;
    end
    // A strobe edge during a word is dropped
    if (wordDone && outputLatchLoadStrobeN) begin
      transfer = 1'b0;
    end
  end

  output_latch_pair u_latches (
    .clk        (clk),
    .reset_n    (reset_n),
    .writeInput (writeInput),
    .writeData  (wordIn[CODE_BITS-1:0]),
    .transfer   (transfer),
    .outputCode (outputCode)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q           <= '0;
      state_q.startPrev <= 1'b1;
      state_q.tclkPrev  <= 1'b1;
      state_q.loadPrev  <= 1'b1;
      state_q.clkPin    <= PIN_RELEASED;
      state_q.framePin  <= PIN_RELEASED;
      state_q.dataPin   <= PIN_RELEASED;
    end else begin
      state_q <= state_d;
    end
  end

  assign receiveClockPin    = state_q.clkPin;
  assign receiveFrameStrobe = state_q.framePin;
  assign receiveDataPin     = state_q.dataPin;
  assign trackHoldHold      = state_q.hold;
  assign converting         = state_q.converting;

endmodule
`default_nettype wire

// ===== dv/serial_adc_dac_interface_chk.sv
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module serial_adc_dac_interface_chk
  import converter_io_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic                     conversionStartStrobeN,
  input wire converter_io_pkg::code_t  sampleCode,
  input wire logic                     receiveClockContinuous,
  input wire logic                     transmitSerialClock,
  input wire logic                     transmitFrameSyncN,
  input wire logic                     transmitDataIn,
  input wire logic                     outputLatchLoadStrobeN,
  input wire converter_io_pkg::odPin_t receiveClockPin,
  input wire converter_io_pkg::odPin_t receiveFrameStrobe,
  input wire converter_io_pkg::odPin_t receiveDataPin,
  input wire logic                     trackHoldHold,
  input wire logic                     converting,
  input wire converter_io_pkg::code_t  outputCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] convCnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) convCnt_q <= '0;
    else convCnt_q <= converting ? convCnt_q + 10'h001 : '0;
  end
  start_hold_a: assert property ($rose(conversionStartStrobeN) && !converting && receiveFrameStrobe.oeN
    |=> converting && trackHoldHold) else $error("start did not enter hold");
  frame_start_a: assert property ($rose(conversionStartStrobeN) && !converting && receiveFrameStrobe.oeN
    |=> !receiveFrameStrobe.oeN && !receiveDataPin.oeN) else $error("frame or first zero missing");
  hold_end_a: assert property ($fell(converting) |-> !trackHoldHold) else $error("hold kept after end");
  od_low_a: assert property (!receiveClockPin.out && !receiveFrameStrobe.out && !receiveDataPin.out)
    else $error("pin drives high");
  frame_data_a: assert property (receiveFrameStrobe.oeN |-> receiveDataPin.oeN)
    else $error("data held outside frame");
  data_stable_a: assert property ($fell(receiveClockPin.oeN) && !receiveFrameStrobe.oeN
    && !$past(receiveFrameStrobe.oeN) |-> $stable(receiveDataPin.oeN)) else $error("data moved at falling clock");
  gated_idle_a: assert property (!receiveClockContinuous && receiveFrameStrobe.oeN && !converting
    && !$past(converting) |-> receiveClockPin.oeN) else $error("gated clock runs while idle");
  cont_runs_a: assert property (receiveClockContinuous && $past(receiveClockContinuous)
    |-> ##[1:11] $changed(receiveClockPin.oeN)) else $error("continuous clock stopped");
  code_cause_a: assert property ($changed(outputCode) |-> !$past(outputLatchLoadStrobeN))
    else $error("code changed with load high");
  conv_len_a: assert property ($fell(converting) |-> convCnt_q >= 10'(36 * MCLK_HALF_CYCLES)
    && convCnt_q <= 10'(40 * MCLK_HALF_CYCLES)) else $error("conversion length wrong");
  cover property ($fell(converting));
  cover property (receiveClockContinuous && $fell(receiveFrameStrobe.oeN));
  cover property ($changed(outputCode));
endmodule

bind serial_adc_dac_interface serial_adc_dac_interface_chk chk (.*);
`default_nettype wire

// ===== dv/host_serial_port.sv
// Host serial port model: word sender and receive word capture
`timescale 1ns/1ps
`default_nettype none
module host_serial_port
  import converter_io_pkg::*;
(
  input  wire logic clk,
  input  wire logic rxClkLvl,
  input  wire logic frameLvl,
  input  wire logic rxDataLvl,
  output logic      txClk,
  output logic      syncN,
  output logic      txData,
  output word_t     rxWord,
  output int        rxCount
);
  logic rxClkPrev;
  initial begin
    txClk = 1'b1;
    syncN = 1'b1;
    txData = 1'b0;
    rxWord = '0;
    rxCount = 0;
    rxClkPrev = 1'b1;
  end
  // Sample on falling receive clock while framed
  always @(posedge clk) begin
    if (rxClkPrev && !rxClkLvl && !frameLvl) begin
      rxWord <= {rxWord[14:0], rxDataLvl};
      rxCount <= rxCount + 1;
    end
    rxClkPrev <= rxClkLvl;
  end
  task automatic sendWord(input word_t w);
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      @(posedge clk) #1;
      txClk = 1'b1;
      txData = w[i];
      syncN = (i != WORD_BITS - 1);
      repeat (3) @(posedge clk);
      #1 txClk = 1'b0;
      repeat (3) @(posedge clk);
    end
    // Hold time over: line no longer shows the last bit
    #1 txData = ~txData;
  endtask
endmodule
`default_nettype wire

// ===== dv/serial_adc_dac_interface_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module serial_adc_dac_interface_tb_top;
  import converter_io_pkg::*;
  logic   clk, reset_n, startN, contMode, loadN, txClk, syncN, txData, hold, conv;
  logic   rxClkLvl, frameLvl, rxDataLvl;
  code_t  sample, outCode;
  odPin_t rxClkPin, framePin, rxDataPin;
  word_t  rxWord;
  int     rxCount, fails, checked;
  assign rxClkLvl = rxClkPin.oeN ? 1'b1 : rxClkPin.out;
  assign frameLvl = framePin.oeN ? 1'b1 : framePin.out;
  assign rxDataLvl = rxDataPin.oeN ? 1'b1 : rxDataPin.out;
  serial_adc_dac_interface dut (.clk(clk), .reset_n(reset_n), .conversionStartStrobeN(startN),
    .sampleCode(sample), .receiveClockContinuous(contMode), .transmitSerialClock(txClk),
    .transmitFrameSyncN(syncN), .transmitDataIn(txData), .outputLatchLoadStrobeN(loadN),
    .receiveClockPin(rxClkPin), .receiveFrameStrobe(framePin), .receiveDataPin(rxDataPin),
    .trackHoldHold(hold), .converting(conv), .outputCode(outCode));
  host_serial_port host (.clk(clk), .rxClkLvl(rxClkLvl), .frameLvl(frameLvl), .rxDataLvl(rxDataLvl),
    .txClk(txClk), .syncN(syncN), .txData(txData), .rxWord(rxWord), .rxCount(rxCount));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test;
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic adcWord(input logic cont, input code_t code);
    int base;
    base = rxCount;
    contMode = cont;
    sample = code;
    startN = 1'b0;
    @(posedge clk) #1 startN = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(conv === 1'b1 && hold === 1'b1, "no hold at start");
    check(frameLvl === 1'b0 && rxDataLvl === 1'b0, "frame or zero missing");
    repeat (50) @(posedge clk);
    #1 startN = 1'b0;
    @(posedge clk) #1 startN = 1'b1;
    for (int n = 0; n < 1000 && rxCount < base + 16; n++) @(posedge clk);
    repeat (15) @(posedge clk);
    #1 check(rxWord === {LEAD_ZEROS, code} && rxCount === base + 16, "word wrong");
    check(frameLvl === 1'b1, "frame kept low");
    for (int n = 0; n < 500 && conv !== 1'b0; n++) @(posedge clk);
    repeat (15) @(posedge clk);
    #1 check(conv === 1'b0 && hold === 1'b0 && (cont || rxClkLvl === 1'b1), "end state wrong");
  endtask
  task automatic dacHeldLow;
    loadN = 1'b0;
    host.sendWord({2'b11, 14'h1fff});
    @(posedge clk) #1 check(outCode === 14'h1fff, "auto load missed");
    loadN = 1'b1;
  endtask
  task automatic dacExplicit;
    host.sendWord({2'b10, 14'h2000});
    repeat (4) @(posedge clk);
    #1 check(outCode === 14'h1fff, "loaded without strobe");
    loadN = 1'b0;
    repeat (2) @(posedge clk);
    #1 check(outCode === 14'h2000, "strobe load missed");
    loadN = 1'b1;
  endtask
  task automatic dacMidStayLow;
    fork
      host.sendWord({2'b01, 14'h0000});
      begin
        repeat (40) @(posedge clk);
        #1 loadN = 1'b0;
        repeat (3) @(posedge clk);
        #1 check(outCode === 14'h2000, "mid word fall loaded");
      end
    join
    @(posedge clk) #1 check(outCode === 14'h0000, "end of word load missed");
    loadN = 1'b1;
  endtask
  task automatic dacMidPulse;
    fork
      host.sendWord({2'b00, 14'h1234});
      begin
        repeat (40) @(posedge clk);
        #1 loadN = 1'b0;
        repeat (20) @(posedge clk);
        #1 loadN = 1'b1;
      end
    join
    repeat (2) @(posedge clk);
    #1 check(outCode === 14'h0000, "aborted load updated");
    loadN = 1'b0;
    repeat (2) @(posedge clk);
    #1 check(outCode === 14'h1234, "input latch lost");
    loadN = 1'b1;
  endtask
  initial begin
    fails = 0;
    checked = 0;
    reset_n = 1'b0;
    startN = 1'b1;
    contMode = 1'b0;
    loadN = 1'b1;
    sample = '0;
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(outCode === 14'h0000 && frameLvl === 1'b1 && conv === 1'b0, "reset state wrong");
    adcWord(1'b0, 14'h1fff);
    adcWord(1'b0, 14'h2000);
    adcWord(1'b1, 14'h3fff);
    dacHeldLow();
    dacExplicit();
    dacMidStayLow();
    dacMidPulse();
    stop_test();
  end
  initial begin
    #(25.0 * 10000);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
